//--- can_tx_retry_and_rx_store.sv
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`include "can_store_consts.svh"
module can_tx_retry_and_rx_store #(
  parameter int NBUF = 32,
  parameter int WD_WIDTH = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit attempt outcome from the protocol engine
  input wire can_store_pkg::tx_result_type tx_result,
  // received words from the protocol engine
  input wire can_store_pkg::rx_word_type rx_word,
  // message ram arbiter
  output logic ram_req,
  input wire logic ram_grant,
  output logic ram_we,
  output logic [31:0] ram_wdata,
  output logic ram_frame_end,
  // interrupt
  output logic irq
);
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
  logic rvalid_q, rvalid_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] cfg_q, cfg_d, mask_q, mask_d;
  logic [WD_WIDTH-1:0] wdog_q, wdog_d;
  logic [3:0] flag_q, flag_d;
  logic [NBUF-1:0] add_req;
  logic [NBUF-1:0] pend_bits, cancel_bits;
  logic done_ev, lost_ev, wd_fire, fail_ev, do_write, do_read;
  logic [31:0] wmask;
  can_store_pkg::store_state_type st_q, st_d;
  logic req_q, req_d, we_q, we_d, end_q, end_d, start_wd;
  logic [31:0] wd_q, wd_d;
  tx_retry_tracker #(.NBUF(NBUF)) u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .no_auto_retransmit_mode(cfg_q[`BIT_NO_AUTO_RETX]),
    .add_request(add_req),
    .result(tx_result),
    .tx_request_pending_reg(pend_bits),
    .tx_cancel_finished_reg(cancel_bits),
    .done_event(done_ev),
    .lost_event(lost_ev)
  );
  ram_watchdog #(.WIDTH(WD_WIDTH)) u_wd (
    .aclk(aclk),
    .aresetn(aresetn),
    .load_value(wdog_q),
    .start(start_wd),
    .waiting(req_q && !ram_grant),
    .fire(wd_fire)
  );
  // receive storage: a frame is written word by word while granted
  always_comb
  begin
    st_d = st_q;
    req_d = req_q;
    we_d = 1'b0;
    end_d = 1'b0;
    wd_d = wd_q;
    start_wd = 1'b0;
    fail_ev = 1'b0;
    case (st_q)
      can_store_pkg::ST_IDLE:
      begin
        if (rx_word.valid)
        begin
          req_d = 1'b1;
          start_wd = 1'b1;
          wd_d = rx_word.data;
          st_d = can_store_pkg::ST_WAIT;
        end
      end
      can_store_pkg::ST_WAIT:
      begin
        if (ram_grant)
        begin
          we_d = 1'b1;
          end_d = 1'b0;
          st_d = can_store_pkg::ST_WRITE;
        end
        else if (rx_word.valid)
        begin
          // arbiter too slow: frame lost, remainder dropped
          fail_ev = 1'b1;
          req_d = 1'b0;
          st_d = can_store_pkg::ST_DROP;
        end
      end
      can_store_pkg::ST_WRITE:
      begin
        if (rx_word.valid)
        begin
          we_d = 1'b1;
          wd_d = rx_word.data;
          end_d = rx_word.last;
          if (rx_word.last)
          begin
            req_d = 1'b0;
            st_d = can_store_pkg::ST_IDLE;
          end
        end
      end
      default:
      begin
        // dropping ends only on a last word; if the lost frame's last word came in ST_WAIT, the whole following frame is dropped
        if (rx_word.valid && rx_word.last)
        begin
          st_d = can_store_pkg::ST_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= can_store_pkg::ST_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      end_q <= 1'b0;
      wd_q <= 32'h0000_0000;
    end
    else
    begin
      st_q <= st_d;
      req_q <= req_d;
      we_q <= we_d;
      end_q <= end_d;
      wd_q <= wd_d;
    end
  end
  assign ram_req = req_q;
  assign ram_we = we_q;
  assign ram_wdata = wd_q;
  assign ram_frame_end = end_q;
  assign irq = |(flag_q & mask_q[3:0]);
  // register bus
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    cfg_d = cfg_q;
    mask_d = mask_q;
    wdog_d = wdog_q;
    flag_d = flag_q;
    add_req = '0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    for (int i = 0; i < 4; i++)
    begin
      wmask[8*i +: 8] = {8{wstrb_q[i]}};
    end
    do_write = aw_have_q && w_have_q;
    do_read = s_axi_arvalid && s_axi_arready;
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = 2'h0;
      if (awaddr_q[11:2] == `OFS_CORE_CONFIG >> 2)
      begin
        cfg_d = (cfg_q & ~wmask) | (wdata_q & wmask & 32'h0000_0001);
      end
      else if (awaddr_q[11:2] == `OFS_IRQ_MASK >> 2)
      begin
        mask_d = (mask_q & ~wmask) | (wdata_q & wmask & 32'h0000_000F);
      end
      else if (awaddr_q[11:2] == `OFS_RAM_WDOG >> 2)
      begin
        wdog_d = WD_WIDTH'((32'(wdog_q) & ~wmask) | (wdata_q & wmask));
      end
      else if (awaddr_q[11:2] == `OFS_TX_ADD >> 2)
      begin
        add_req = NBUF'(wdata_q & wmask);
      end
      else if (awaddr_q[11:2] != `OFS_TX_PENDING >> 2 &&
               awaddr_q[11:2] != `OFS_TX_CANCEL >> 2 &&
               awaddr_q[11:2] != `OFS_IRQ_FLAG >> 2 &&
               awaddr_q[11:2] != `OFS_IDENT >> 2)
      begin
        bresp_d = 2'h2;
      end
    end
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (do_read)
    begin
      rvalid_d = 1'b1;
      rresp_d = 2'h0;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr[11:2] == `OFS_CORE_CONFIG >> 2)
      begin
        rdata_d = cfg_q;
      end
      else if (s_axi_araddr[11:2] == `OFS_TX_PENDING >> 2)
      begin
        rdata_d = 32'(pend_bits);
      end
      else if (s_axi_araddr[11:2] == `OFS_TX_CANCEL >> 2)
      begin
        rdata_d = 32'(cancel_bits);
      end
      else if (s_axi_araddr[11:2] == `OFS_IRQ_FLAG >> 2)
      begin
        rdata_d = {28'h000_0000, flag_q};
        flag_d = 4'h0;
      end
      else if (s_axi_araddr[11:2] == `OFS_IRQ_MASK >> 2)
      begin
        rdata_d = mask_q;
      end
      else if (s_axi_araddr[11:2] == `OFS_RAM_WDOG >> 2)
      begin
        rdata_d = 32'(wdog_q);
      end
      else if (s_axi_araddr[11:2] == `OFS_IDENT >> 2)
      begin
        rdata_d = `IDENT_VALUE;
      end
      else if (s_axi_araddr[11:2] != `OFS_TX_ADD >> 2)
      begin
        rresp_d = 2'h2;
      end
    end
    // new events win over the read-clear
    if (fail_ev)
    begin
      flag_d[`BIT_RAM_FAIL] = 1'b1;
    end
    if (wd_fire)
    begin
      flag_d[`BIT_RAM_WDOG] = 1'b1;
    end
    if (done_ev)
    begin
      flag_d[`BIT_TX_DONE] = 1'b1;
    end
    if (lost_ev)
    begin
      flag_d[`BIT_TX_LOST] = 1'b1;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      cfg_q <= `RST_CORE_CONFIG;
      mask_q <= 32'h0000_0000;
      wdog_q <= WD_WIDTH'(`RST_RAM_WDOG);
      flag_q <= 4'h0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      cfg_q <= cfg_d;
      mask_q <= mask_d;
      wdog_q <= wdog_d;
      flag_q <= flag_d;
    end
  end
endmodule // can_tx_retry_and_rx_store

//--- can_store_consts.svh
`ifndef CAN_STORE_CONSTS_SVH
`define CAN_STORE_CONSTS_SVH
// register byte offsets
`define OFS_CORE_CONFIG 12'h000
`define OFS_TX_PENDING 12'h004
`define OFS_TX_CANCEL 12'h008
`define OFS_IRQ_FLAG 12'h00C
`define OFS_IRQ_MASK 12'h010
`define OFS_RAM_WDOG 12'h014
`define OFS_TX_ADD 12'h018
`define OFS_IDENT 12'h01C
// field positions
`define BIT_NO_AUTO_RETX 0
`define BIT_RAM_FAIL 0
`define BIT_RAM_WDOG 1
`define BIT_TX_DONE 2
`define BIT_TX_LOST 3
// reset values
`define RST_CORE_CONFIG 32'h0000_0000
`define RST_RAM_WDOG 16'h00FF
// arbitrary identification value
`define IDENT_VALUE 32'h1234_5678
// identifier bit count in which the mis-attribution can occur
`define EARLY_ID_BITS 2
`endif

//--- can_store_pkg.sv
package can_store_pkg;
  typedef struct packed {
    logic valid;
    logic [4:0] buf_idx;
    logic success;
    logic lost_arb;
    logic [4:0] lost_bit;
    logic bus_error;
  } tx_result_type;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic last;
  } rx_word_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_WRITE,
    ST_DROP
  } store_state_type;
endpackage

//--- ram_watchdog.sv
module ram_watchdog #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic [WIDTH-1:0] load_value,
  input wire logic start,
  input wire logic waiting,
  // result
  output logic fire
);
  logic [WIDTH-1:0] count_q, count_d;
  logic run_q, run_d;
  always_comb
  begin
    count_d = count_q;
    run_d = run_q;
    fire = 1'b0;
    if (start)
    begin
      count_d = load_value;
      run_d = (load_value != '0);
    end
    else if (run_q && waiting)
    begin
      if (count_q <= WIDTH'(1))
      begin
        fire = 1'b1;
        run_d = 1'b0;
        count_d = '0;
      end
      else
      begin
        count_d = count_q - WIDTH'(1);
      end
    end
    else if (!waiting)
    begin
      run_d = 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      run_q <= run_d;
    end
  end
endmodule // ram_watchdog

//--- tx_retry_tracker.sv
module tx_retry_tracker #(
  parameter int NBUF = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // mode and software requests
  input wire logic no_auto_retransmit_mode,
  input wire logic [NBUF-1:0] add_request,
  // outcome of each transmit attempt
  input wire can_store_pkg::tx_result_type result,
  // flags
  output logic [NBUF-1:0] tx_request_pending_reg,
  output logic [NBUF-1:0] tx_cancel_finished_reg,
  output logic done_event,
  output logic lost_event
);
  logic [NBUF-1:0] pend_q, pend_d, cancel_q, cancel_d;
  logic [4:0] prev_q, prev_d;
  logic [4:0] target;
  logic early_loss;
  always_comb
  begin
    pend_d = pend_q;
    cancel_d = cancel_q;
    prev_d = prev_q;
    done_event = 1'b0;
    lost_event = 1'b0;
    early_loss = result.lost_arb && (result.lost_bit < 5'(`EARLY_ID_BITS));
    // the defect: an early arbitration loss marks the previous buffer
    target = (early_loss) ? prev_q : result.buf_idx;
    if (result.valid)
    begin
      prev_d = result.buf_idx;
      if (result.success)
      begin
        pend_d[result.buf_idx] = 1'b0;
        done_event = 1'b1;
      end
      else if (no_auto_retransmit_mode)
      begin
        // no retry; the request is dropped and cancel reported
        pend_d[target] = 1'b0;
        cancel_d[target] = 1'b1;
        lost_event = 1'b1;
      end
      // pend bit still set for the real buffer means one more attempt
    end
    for (int i = 0; i < NBUF; i++)
    begin
      if (add_request[i])
      begin
        pend_d[i] = 1'b1;
        cancel_d[i] = 1'b0;
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_q <= '0;
      cancel_q <= '0;
      prev_q <= 5'h00;
    end
    else
    begin
      pend_q <= pend_d;
      cancel_q <= cancel_d;
      prev_q <= prev_d;
    end
  end
  assign tx_request_pending_reg = pend_q;
  assign tx_cancel_finished_reg = cancel_q;
endmodule // tx_retry_tracker

//--- ram_arb_model.sv
module ram_arb_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // arbiter side
  input wire logic ram_req,
  input wire logic [31:0] delay,
  output logic ram_grant = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  // grant comes delay cycles after the request is seen and stays until it drops
  always @(posedge aclk)
  begin
    if (!aresetn || !ram_req)
    begin
      cnt <= 0;
      ram_grant <= 1'h0;
    end
    else
    begin
      cnt <= cnt + 1;
      ram_grant <= (cnt + 1 >= delay);
    end
  end
endmodule // ram_arb_model

//--- can_tx_retry_and_rx_store_assertions.sv
module can_tx_retry_and_rx_store_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // receive store
  input wire can_store_pkg::rx_word_type rx_word,
  input wire logic ram_req,
  input wire logic ram_grant,
  input wire logic ram_we,
  input wire logic ram_frame_end
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_req_rise; $rose(ram_req) |-> $past(rx_word.valid); endproperty
  a_req_rise: assert property (p_req_rise)
    else $error("ram request raised without a word");
  property p_we_cause; ram_we |-> $past(rx_word.valid) || $past(ram_grant); endproperty
  a_we_cause: assert property (p_we_cause)
    else $error("ram write without word or grant");
  property p_end_we; ram_frame_end |-> ram_we; endproperty
  a_end_we: assert property (p_end_we)
    else $error("frame end without ram write");
  property p_fail_drop; ram_req && !ram_grant && rx_word.valid |=> !ram_req; endproperty
  a_fail_drop: assert property (p_fail_drop)
    else $error("ram request kept after late grant");
  property p_req_hold;
    ram_req && ram_grant && !rx_word.valid && !ram_we |=> ram_req;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("granted request dropped mid frame");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_r_cause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
  a_r_cause: assert property (p_r_cause)
    else $error("read data without address");
  c_frame: cover property (ram_frame_end);
  c_fail: cover property (ram_req && !ram_grant && rx_word.valid);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // can_tx_retry_and_rx_store_assertions

bind can_tx_retry_and_rx_store can_tx_retry_and_rx_store_assertions i_chk (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .rx_word, .ram_req, .ram_grant, .ram_we, .ram_frame_end);

//--- can_tx_retry_and_rx_store_tb.sv
module can_tx_retry_and_rx_store_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ram_req, ram_grant, ram_we, ram_frame_end, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, ram_wdata;
  can_store_pkg::tx_result_type tx_result = 14'h0;
  can_store_pkg::rx_word_type rx_word = 34'h0;
  int failures = 0, comparisons = 0, gdly = 1, prev = 0, ends = 0;
  logic [31:0] pend = 32'h0, canc = 32'h0, msk;
  logic [31:0] got_q[$], exp_q[$];
  logic mode = 1'h0;

  always #2.5 aclk = ~aclk;

  can_tx_retry_and_rx_store #(.NBUF(32), .WD_WIDTH(16)) i_can_tx_retry_and_rx_store (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_result, .rx_word, .ram_req, .ram_grant, .ram_we, .ram_wdata, .ram_frame_end, .irq);
  ram_arb_model i_ram_arb_model (.aclk, .aresetn, .ram_req, .delay(gdly), .ram_grant);

  always @(posedge aclk)
  begin
    if (aresetn && ram_we)
      got_q.push_back(ram_wdata);
    if (aresetn && ram_frame_end)
      ends++;
  end

  task final_report;
    $display("mismatches %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      if (tb)
        chk({30'h0, s_axi_bresp}, {30'h0, r});
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'h0;
      if (tw)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r, input logic [31:0] m);
    logic ta, tr;
    tr = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tr)
    begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      if (tr)
      begin
        chk(s_axi_rdata & m, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
      end
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  // one finished attempt, then both flag registers against the model
  task tx(input logic [4:0] i, input logic s, input logic l, input logic [4:0] lb,
          input logic e);
    int t;
    tx_result <= {1'h1, i, s, l, lb, e};
    @(posedge aclk);
    tx_result <= 14'h0;
    t = (l && lb < 2) ? prev : i;
    if (s)
      pend[i] = 1'h0;
    else if (mode)
    begin
      pend[t] = 1'h0;
      canc[t] = 1'h1;
    end
    prev = i;
    @(posedge aclk);
    rd(12'h004, pend, 2'h0, 32'hFFFF_FFFF);
    rd(12'h008, canc, 2'h0, 32'hFFFF_FFFF);
  endtask

  task frame(input int n, input int gap, input logic keep);
    logic [31:0] d;
    for (int k = 0; k < n; k++)
    begin
      d = $urandom;
      if (keep)
        exp_q.push_back(d);
      rx_word <= {1'h1, d, k == n - 1};
      @(posedge aclk);
      rx_word <= 34'h0;
      repeat (gap) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
    chk(got_q.size(), exp_q.size());
    chk(ends, 32'(keep));
    ends = 0;
    foreach (exp_q[k])
      if (k < got_q.size())
        chk(got_q[k], exp_q[k]);
    got_q.delete();
    exp_q.delete();
  endtask

  // hang guard
  initial
  begin
    #20us;
    failures++;
    final_report;
  end

  initial
  begin
    void'($urandom(32'hc0b1febb));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(12'h014, 32'h0000_00FF, 2'h0, 32'hFFFF_FFFF);
    rd(12'h000, 32'h0, 2'h0, 32'hFFFF_FFFF);
    rd(12'h01C, 32'h1234_5678, 2'h0, 32'hFFFF_FFFF);
    rd(12'h020, 32'h0, 2'h2, 32'hFFFF_FFFF);
    wr(12'h020, 32'h0, 2'h2);
    wr(12'h004, 32'hFFFF_FFFF, 2'h0);
    msk = $urandom | 32'h0000_02BD;
    wr(12'h018, msk, 2'h0);
    pend = msk;
    wr(12'h000, 32'h1, 2'h0);
    mode = 1'h1;
    tx(5'h4, 1'h0, 1'h1, 5'h0, 1'h0);
    tx(5'h3, 1'h1, 1'h0, 5'h0, 1'h0);
    tx(5'h5, 1'h0, 1'h0, 5'h0, 1'h1);
    tx(5'h7, 1'h0, 1'h1, 5'h1, 1'h0);
    tx(5'h7, 1'h0, 1'h1, 5'h0, 1'h0);
    tx(5'h9, 1'h0, 1'h1, 5'h2, 1'h0);
    wr(12'h000, 32'h0, 2'h0);
    mode = 1'h0;
    tx(5'h2, 1'h0, 1'h1, 5'h5, 1'h0);
    // done and no-retry events of the attempts above, cleared by this read
    rd(12'h00C, 32'h0000_000C, 2'h0, 32'hFFFF_FFFF);
    wr(12'h014, 32'h4, 2'h0);
    wr(12'h010, 32'h3, 2'h0);
    gdly <= 1;
    frame(3, 2, 1'h1);
    rd(12'h00C, 32'h0, 2'h0, 32'h3);
    wr(12'h010, 32'h0, 2'h0);
    gdly <= 1000;
    frame(3, 6, 1'h0);
    chk({31'h0, irq}, 32'h0);
    wr(12'h010, 32'h3, 2'h0);
    chk({31'h0, irq}, 32'h1);
    rd(12'h00C, 32'h3, 2'h0, 32'h3);
    chk({31'h0, irq}, 32'h0);
    gdly <= 1;
    // grant must land before the second word, so words are three cycles apart
    frame(2, 2, 1'h1);
    final_report;
  end
endmodule // can_tx_retry_and_rx_store_tb
